//--- pkg/ebr_pkg.sv
package ebr_pkg;
   ////////////////////////////////////////////////////////////////////////
   // array geometry
   localparam int TOTAL_BITS = 4608;
   localparam int NARROW_W   = 9;
   localparam int WIDE_W     = 18;
   localparam int DEPTH      = 512;
   localparam int WIDE_DEPTH = 256;
   localparam int ADDR_W     = 9;
   localparam int WADDR_W    = 8;
   ////////////////////////////////////////////////////////////////////////
   // cascade select field and port count
   localparam int SEL_W      = 2;
   localparam int PORTS      = 2;
   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [WIDE_W-1:0] DOUT_RST = 18'h00000;
   localparam logic [1:0]        RST_SYNC = 2'h0;
endpackage

//--- rtl/ebr_store.sv
module ebr_store #(
   parameter int DEPTH = ebr_pkg::DEPTH,
   parameter int W     = ebr_pkg::NARROW_W,
   parameter int AW    = ebr_pkg::ADDR_W
) (
   input  wire logic            clk,
   input  wire logic [1:0]      wr_en,
   input  wire logic            wr_wide,
   input  wire logic [AW-1:0]   wr_idx   [2],
   input  wire logic [2*W-1:0]  wr_data  [2],
   input  wire logic [AW-1:0]   rd_idx   [2],
   output logic      [2*W-1:0]  rd_data  [2]
);
   logic [W-1:0] mem [DEPTH];

   // port 1 is written first so port 0 wins an address collision
   always_ff @(posedge clk) begin
      for (int p = 1; p >= 0; p--) begin
         if (wr_en[p]) begin
            mem[wr_idx[p]] <= wr_data[p][W-1:0];
            if (wr_wide) begin
               mem[wr_idx[p] | AW'(1)] <= wr_data[p][2*W-1:W];
            end
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         rd_data[p] = {mem[rd_idx[p] | AW'(1)], mem[rd_idx[p]]};
      end
   end
endmodule

//--- rtl/embedded_block_ram.sv
module embedded_block_ram #(
   parameter int                        SEL_W    = ebr_pkg::SEL_W,
   parameter logic [ebr_pkg::SEL_W-1:0] BLOCK_ID = 2'h0
) (
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   input  wire logic                          WIDE_MODE,
   input  wire logic                          DUAL_MODE,
   input  wire logic                          CASCADE_EN,
   input  wire logic                          A_CLK,
   input  wire logic                          A_CLK_INV,
   input  wire logic                          A_ASYNC_RD,
   input  wire logic                          A_CE_B,
   input  wire logic                          A_WE,
   input  wire logic                          A_OE,
   input  wire logic [ebr_pkg::ADDR_W-1:0]    A_ADDR,
   input  wire logic [SEL_W-1:0]              A_COL_SEL,
   input  wire logic [ebr_pkg::WIDE_W-1:0]    A_DIN,
   output logic      [ebr_pkg::WIDE_W-1:0]    A_DOUT,
   output logic                               A_DOUT_EN,
   input  wire logic                          B_CLK,
   input  wire logic                          B_CLK_INV,
   input  wire logic                          B_ASYNC_RD,
   input  wire logic                          B_CE_B,
   input  wire logic                          B_WE,
   input  wire logic                          B_OE,
   input  wire logic [ebr_pkg::ADDR_W-1:0]    B_ADDR,
   input  wire logic [SEL_W-1:0]              B_COL_SEL,
   input  wire logic [ebr_pkg::WIDE_W-1:0]    B_DIN,
   output logic      [ebr_pkg::WIDE_W-1:0]    B_DOUT,
   output logic                               B_DOUT_EN
);
   localparam int AW = ebr_pkg::ADDR_W;
   localparam int DW = ebr_pkg::WIDE_W;
   localparam int NW = ebr_pkg::NARROW_W;

   ////////////////////////////////////////////////////////////////////////
   // reset release
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_r <= ebr_pkg::RST_SYNC;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [AW-1:0] word_index(
      input logic          wide,
      input logic [AW-1:0] addr
   );
      // a wide word occupies an even/odd pair of narrow cells
      word_index = wide ? {addr[ebr_pkg::WADDR_W-1:0], 1'b0} : addr;
   endfunction

   function automatic logic block_hit(
      input logic             casc,
      input logic [SEL_W-1:0] sel
   );
      block_hit = !casc || (sel == BLOCK_ID);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // gather the two ports into arrays
   logic [1:0]    pclk;
   logic [1:0]    pclk_inv;
   logic [1:0]    async_rd;
   logic [1:0]    ce_b;
   logic [1:0]    we;
   logic [1:0]    oe;
   logic [1:0]    port_on;
   logic [AW-1:0] addr    [2];
   logic [SEL_W-1:0] col_sel [2];
   logic [DW-1:0] din     [2];

   assign pclk       = {B_CLK, A_CLK};
   assign pclk_inv   = {B_CLK_INV, A_CLK_INV};
   assign async_rd   = {B_ASYNC_RD, A_ASYNC_RD};
   assign ce_b       = {B_CE_B, A_CE_B};
   assign we         = {B_WE, A_WE};
   assign oe         = {B_OE, A_OE};
   // single-port arrangement blocks port B writes, registered reads and B_DOUT_EN; an async B read still drives B_DOUT
   assign port_on    = {DUAL_MODE, 1'b1};
   assign addr[0]    = A_ADDR;
   assign addr[1]    = B_ADDR;
   assign col_sel[0] = A_COL_SEL;
   assign col_sel[1] = B_COL_SEL;
   assign din[0]     = A_DIN;
   assign din[1]     = B_DIN;

   ////////////////////////////////////////////////////////////////////////
   // per-port control
   logic [1:0]    pclk_q_r;
   logic [1:0]    act;
   logic [1:0]    hit;
   logic [1:0]    en;
   logic [1:0]    st_we;
   logic [AW-1:0] idx     [2];
   logic [DW-1:0] st_rd   [2];
   logic [DW-1:0] rd_word [2];
   logic [DW-1:0] dout_r  [2];
   logic [DW-1:0] dout    [2];
   logic [1:0]    dout_en;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pclk_q_r <= 2'h0;
      end else begin
         pclk_q_r <= pclk;
      end
   end

   for (genvar p = 0; p < ebr_pkg::PORTS; p++) begin : g_port
      // the port clock is a same-domain level; its active edge is a pulse
      assign act[p] = pclk_inv[p] ? (pclk_q_r[p] && !pclk[p])
                                  : (pclk[p] && !pclk_q_r[p]);
      assign hit[p] = block_hit(CASCADE_EN, col_sel[p]);
      assign en[p]  = port_on[p] && hit[p] && !ce_b[p];
      assign idx[p] = word_index(WIDE_MODE, addr[p]);
      assign st_we[p] = act[p] && en[p] && we[p];
      assign rd_word[p] = WIDE_MODE ? st_rd[p]
                                    : {{(DW-NW){1'b0}}, st_rd[p][NW-1:0]};

      always_ff @(posedge CLK or negedge rst_n) begin
         if (!rst_n) begin
            dout_r[p] <= ebr_pkg::DOUT_RST;
         end else if (act[p] && en[p] && !we[p]) begin
            dout_r[p] <= rd_word[p];
         end
      end

      // asynchronous mode trades a registered output for zero latency
      assign dout[p] = async_rd[p] ? rd_word[p] : dout_r[p];
      assign dout_en[p] = oe[p] && port_on[p] && hit[p];
   end

   assign A_DOUT    = dout[0];
   assign B_DOUT    = dout[1];
   assign A_DOUT_EN = dout_en[0];
   assign B_DOUT_EN = dout_en[1];

   ////////////////////////////////////////////////////////////////////////
   // storage
   ebr_store #(
      .DEPTH (ebr_pkg::DEPTH),
      .W     (NW),
      .AW    (AW)
   ) u_store (
      .clk     (CLK),
      .wr_en   (st_we),
      .wr_wide (WIDE_MODE),
      .wr_idx  (idx),
      .wr_data (din),
      .rd_idx  (idx),
      .rd_data (st_rd)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   sequence rd_req_s;
      act[0] && en[0] && !we[0] && !async_rd[0];
   endsequence

   sequence wr_req_s;
      act[0] && en[0] && we[0] && !WIDE_MODE && !st_we[1];
   endsequence

   property sync_read_p;
      logic [DW-1:0] w;
      (rd_req_s, w = rd_word[0]) ##1 !async_rd[0] |-> A_DOUT == w;
   endproperty

   property write_cell_p;
      logic [AW-1:0] i;
      logic [NW-1:0] d;
      (wr_req_s, i = idx[0], d = A_DIN[NW-1:0]) |=>
         u_store.mem[i] == d;
   endproperty

   sequence b_wr_req_s;
      st_we[1] && !st_we[0] && !WIDE_MODE;
   endsequence

   // port B reaches the same cells on its own strobe
   property b_write_p;
      logic [AW-1:0] i;
      logic [NW-1:0] d;
      (b_wr_req_s, i = idx[1], d = B_DIN[NW-1:0]) |=>
         u_store.mem[i] == d;
   endproperty

   store_size_a: assert property (
      ebr_pkg::DEPTH * NW == ebr_pkg::TOTAL_BITS &&
      ebr_pkg::WIDE_DEPTH * DW == ebr_pkg::TOTAL_BITS)
      else $error("array size is not 4608 bits");

   port_isolate_a: assert property (
      !act[1] |-> !st_we[1])
      else $error("port B wrote without its own clock edge");

   narrow_zero_a: assert property (
      !WIDE_MODE |-> rd_word[0][DW-1:NW] == 9'h000)
      else $error("narrow read carried upper bits");

   ce_hold_a: assert property (
      A_CE_B && !A_ASYNC_RD ##1 !A_ASYNC_RD |-> $stable(A_DOUT))
      else $error("port A output moved while clock disabled");

   read_nowrite_a: assert property (
      act[0] && !A_CE_B && !A_WE |-> !st_we[0])
      else $error("read cycle wrote the array");

   sync_read_a: assert property (sync_read_p)
      else $error("sync read word not presented");

   async_follow_a: assert property (
      A_ASYNC_RD |-> A_DOUT == rd_word[0])
      else $error("async output does not follow address");

   casc_block_a: assert property (
      CASCADE_EN && A_COL_SEL != BLOCK_ID |->
         !st_we[0] && !A_DOUT_EN)
      else $error("unselected block responded");

   write_cell_a: assert property (write_cell_p)
      else $error("write did not land in the array");

   b_write_a: assert property (b_write_p)
      else $error("port B write did not land in the array");
endmodule

//--- verification/fabric_port.sv
module fabric_port (
   input  wire logic        clk,
   input  wire logic        inv,
   output logic             port_clk,
   output logic             ce_b,
   output logic             we,
   output logic [8:0]       addr,
   output logic [17:0]      din
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      port_clk = 1'b0;
      ce_b = 1'b1;
      we = 1'b0;
      addr = 9'h000;
      din = 18'h00000;
   end

   ////////////////////////////////////////////////////////////////////////
   // one strobe per access; it rests at the inactive level
   task automatic op(input logic w, input logic c, input logic [8:0] a,
                     input logic [17:0] d);
      @(posedge clk);
      port_clk <= inv;
      ce_b <= c;
      we <= w;
      addr <= a;
      din <= d;
      @(posedge clk);
      port_clk <= ~inv;
      @(posedge clk);
      port_clk <= inv;
      ce_b <= 1'b1;
      // released lines show the inverse, never a stale copy
      addr <= ~a;
      din <= ~d;
   endtask

   task automatic peek(input logic [8:0] a);
      @(posedge clk);
      addr <= a;
   endtask
endmodule

//--- verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic        ww;
      logic [8:0]  wa;
      logic [17:0] d;
      logic        rw;
      logic [8:0]  ra;
      logic [17:0] e;
   } row_t;

   logic        clk, rst_b, wide, dual, casc, a_inv, a_async, b_async;
   logic [1:0]  a_sel;
   logic        a_clk, a_ce_b, a_we, b_clk, b_ce_b, b_we, a_en, b_en, a_oe;
   logic [8:0]  a_addr, b_addr;
   logic [17:0] a_din, b_din, a_dout, b_dout;
   int          errors, compares;
   // narrow views of a wide word pair as cells 2a+1 and 2a
   row_t rows [5] = '{
      '{1'b0, 9'h1FF, 18'h3FFA5, 1'b0, 9'h1FF, 18'h001A5},
      '{1'b1, 9'h0FF, 18'h3FFFF, 1'b1, 9'h0FF, 18'h3FFFF},
      '{1'b1, 9'h010, 18'h2B4CD, 1'b0, 9'h021, 18'h0015A},
      '{1'b0, 9'h020, 18'h00033, 1'b1, 9'h010, 18'h2B433},
      '{1'b0, 9'h000, 18'h00000, 1'b0, 9'h020, 18'h00033}};

   always #25 clk = ~clk;

   embedded_block_ram u_dut (.CLK(clk), .RST_B(rst_b), .WIDE_MODE(wide),
      .DUAL_MODE(dual), .CASCADE_EN(casc), .A_CLK(a_clk),
      .A_CLK_INV(a_inv), .A_ASYNC_RD(a_async), .A_CE_B(a_ce_b),
      .A_WE(a_we), .A_OE(a_oe), .A_ADDR(a_addr), .A_COL_SEL(a_sel),
      .A_DIN(a_din), .A_DOUT(a_dout), .A_DOUT_EN(a_en), .B_CLK(b_clk),
      .B_CLK_INV(1'b0), .B_ASYNC_RD(b_async), .B_CE_B(b_ce_b),
      .B_WE(b_we), .B_OE(1'b1), .B_ADDR(b_addr), .B_COL_SEL(2'h0),
      .B_DIN(b_din), .B_DOUT(b_dout), .B_DOUT_EN(b_en));
   fabric_port u_pa (.clk(clk), .inv(a_inv), .port_clk(a_clk),
      .ce_b(a_ce_b), .we(a_we), .addr(a_addr), .din(a_din));
   fabric_port u_pb (.clk(clk), .inv(1'b0), .port_clk(b_clk),
      .ce_b(b_ce_b), .we(b_we), .addr(b_addr), .din(b_din));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd_a(input logic [8:0] a, input logic [17:0] exp);
      u_pa.op(1'b0, 1'b0, a, 18'h00000);
      @(negedge clk);
      chk(a_dout, exp);
   endtask

   task automatic finish_test;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #100000;
      errors++;
      finish_test();
   end

   initial begin
      {clk, rst_b, wide, dual, casc, a_inv, a_async, b_async} = 8'h00;
      a_sel = 2'h0;
      a_oe = 1'b1;
      errors = 0;
      compares = 0;
      @(negedge clk);
      chk(a_dout, ebr_pkg::DOUT_RST);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         wide <= rows[i].ww;
         u_pa.op(1'b1, 1'b0, rows[i].wa, rows[i].d);
         wide <= rows[i].rw;
         rd_a(rows[i].ra, rows[i].e);
      end
      u_pa.op(1'b1, 1'b1, 9'h1FF, 18'h00000);
      rd_a(9'h1FF, 18'h001FF);
      a_inv <= 1'b1;
      u_pa.op(1'b1, 1'b0, 9'h005, 18'h00077);
      rd_a(9'h005, 18'h00077);
      a_inv <= 1'b0;
      dual <= 1'b1;
      b_async <= 1'b1;
      u_pb.peek(9'h005);
      @(negedge clk);
      chk(b_dout, 18'h00077);
      u_pb.op(1'b1, 1'b0, 9'h006, 18'h00111);
      rd_a(9'h006, 18'h00111);
      dual <= 1'b0;
      u_pb.op(1'b1, 1'b0, 9'h006, 18'h00000);
      rd_a(9'h006, 18'h00111);
      chk1(b_en, 1'b0);
      casc <= 1'b1;
      a_sel <= 2'h1;
      @(negedge clk);
      chk1(a_en, 1'b0);
      u_pa.op(1'b1, 1'b0, 9'h006, 18'h00000);
      a_sel <= 2'h0;
      rd_a(9'h006, 18'h00111);
      chk1(a_en, 1'b1);
      // address switches on the same edge as async mode so the output never shows a blank cell
      u_pa.peek(9'h006);
      a_async <= 1'b1;
      @(negedge clk);
      chk(a_dout, 18'h00111);
      a_oe <= 1'b0;
      @(negedge clk);
      chk1(a_en, 1'b0);
      finish_test();
   end
endmodule
